/* File: pic_arbiter.sv */
// picks the highest pending level, lowest index on a tie
`timescale 1ns/1ps
module pic_arbiter #(
   parameter int N = 24
) (
   input wire logic [N-1:0] i_req,    // pending per source
   input wire logic [N*4-1:0] i_lvl,  // level per source, 4 bits each
   output logic [3:0] o_lvl,          // winning level, 0 if none
   output logic [4:0] o_idx           // winning source index
);
   // strict compare keeps the lower index on equal levels
   always_comb begin
      o_lvl = 4'h0;
      o_idx = 5'h00;
      for (int i = 0; i < N; i++) begin
         if (i_req[i] && (i_lvl[i*4 +: 4] > o_lvl)) begin
            o_lvl = i_lvl[i*4 +: 4];
            o_idx = 5'(i);
         end
      end
   end
endmodule

/* File: pic_controller.sv */
// priority interrupt controller top with register port
// Functional notes
// - judge priority of all pending sources, present the result to the cpu
// - every peripheral, irq and port source has its own 16-level priority
// - eight 16-bit read/write priority registers, all fields reset to zero
// - each priority register holds four 4-bit fields
// - level 0 masks a source, 15 is highest
// - registers a to d assign timers, watchdog, refresh, irq and port groups
// - registers e to h assign dma, serial, adc, usb and pulse units
// - reserved bits and fields read zero; software writes zero there
// - nmi requests are never blocked by the cpu mask level
// - encoded level inputs share irq3..0 pins, one function at a time
// - irq inputs detect low level, high level, rising or falling edge
// - nmi control bit 15 is read-only and shows the nmi pin level
// - after reset the nmi level bit reads 0 until both sync stages hold the pin
// - nmi control bit 8 selects edge: 0 falling, 1 rising, resets 0
// - two sense bits per irq: 00 fall, 01 rise, 10 low, 11 high
// - bit 14 resets 1: irq3..0 become an encoded 15-level bus
// - each port pin has a sense bit choosing low or high level
// - each port pin has an enable bit, reset 0, blocking when 0
`timescale 1ns/1ps
module pic_controller (
   input wire logic i_clk,                 // 125 MHz clock
   input wire logic i_rst,                 // async reset, active high
   input wire logic [3:0] i_addr,          // register word index
   input wire logic [15:0] i_wdata,        // write data
   input wire logic i_wr,                  // write strobe
   input wire logic i_rd,                  // read strobe
   output logic [15:0] o_rdata,            // read data, cycle after i_rd
   input wire logic i_nmi,                 // nmi pin
   input wire logic [5:0] i_irq,           // irq pins, 3..0 double as encoded bus
   input wire logic [15:0] i_port_pins,    // port request pins
   input wire logic [14:0] i_periph_req,   // on-chip peripheral requests
   input wire logic [3:0] i_cpu_mask,      // cpu status register mask level
   input wire logic i_int_ack,             // cpu took the presented request
   input wire logic i_nmi_ack,             // cpu took the nmi
   output logic o_int_req,                 // maskable request to cpu
   output logic [3:0] o_int_level,         // level of that request
   output logic [4:0] o_int_src,           // source index of that request
   output logic o_nmi_req                  // nmi request to cpu
);
   logic [15:0] prio_q [8];
   logic nmi_edge_q;
   logic enc_mode_q;
   logic [11:0] irq_sense_q;
   logic [15:0] port_sense_q;
   logic [15:0] port_en_q;
   logic nmi_s;
   logic nmi_prev_q;
   logic nmi_pend_q;
   logic [5:0] irq_s;
   logic [5:0] irq_prev_q;
   logic [5:0] irq_pend_q;
   logic [5:0] irq_hit;
   logic [15:0] port_s;
   logic [15:0] port_hit;
   logic [pic_pkg::NSRC-1:0] req;
   logic [pic_pkg::NSRC*4-1:0] lvl;
   logic [3:0] win_lvl;
   logic [4:0] win_idx;
   logic [3:0] enc_code;
   logic [15:0] rd_val;
   logic nmi_fire;
   logic int_clear;
   logic [1:0] pins_ok_q;

   // picks field f (3 = bits 15:12) out of a priority register
   function automatic logic [3:0] fld(input logic [15:0] r, input int f);
      fld = r[f*4 +: 4];
   endfunction

   // pin synchronisers
   pic_sync #(.W(1)) u_sync_nmi (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_d(i_nmi),
      .o_q(nmi_s)
   );
   pic_sync #(.W(6)) u_sync_irq (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_d(i_irq),
      .o_q(irq_s)
   );
   pic_sync #(.W(16)) u_sync_port (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_d(i_port_pins),
      .o_q(port_s)
   );

   // the encoded bus source waits until both sync stages hold real pin levels
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pins_ok_q <= 2'h0;
      end else begin
         pins_ok_q <= {pins_ok_q[0], 1'b1};
      end
   end

   // reserved fields never take write data
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int i = 0; i < 8; i++) begin
            prio_q[i] <= pic_pkg::PRIO_RESET;
         end
      end else if (i_wr && (i_addr <= pic_pkg::ADDR_PRIO_H)) begin
         prio_q[i_addr[2:0]] <= i_wdata & pic_pkg::PRIO_WMASK[i_addr[2:0]];
      end
   end

   // edge select, level bit itself is not writable
   // encoded mode bit resets to one
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         nmi_edge_q <= pic_pkg::NMI_EDGE_RESET;
         enc_mode_q <= pic_pkg::ENC_MODE_RESET;
         irq_sense_q <= pic_pkg::IRQ_SENSE_RESET;
         port_sense_q <= pic_pkg::PORT_RESET;
         port_en_q <= pic_pkg::PORT_RESET;
      end else if (i_wr) begin
         if (i_addr == pic_pkg::ADDR_NMI_CTRL) begin
            nmi_edge_q <= i_wdata[pic_pkg::NMI_EDGE_BIT];
         end
         if (i_addr == pic_pkg::ADDR_IRQ_SENSE) begin
            enc_mode_q <= i_wdata[pic_pkg::ENC_MODE_BIT];
            irq_sense_q <= i_wdata[11:0];
         end
         if (i_addr == pic_pkg::ADDR_PORT_SENSE) begin
            port_sense_q <= i_wdata;
         end
         if (i_addr == pic_pkg::ADDR_PORT_EN) begin
            port_en_q <= i_wdata;
         end
      end
   end

   // read mux, unmapped words read zero
   // bit 15 shows the synchronised pin
   // level bit reads 0 after reset until both sync stages hold the pin
   always_comb begin
      rd_val = 16'h0000;
      if (i_addr <= pic_pkg::ADDR_PRIO_H) begin
         rd_val = prio_q[i_addr[2:0]];
      end else if (i_addr == pic_pkg::ADDR_NMI_CTRL) begin
         rd_val[pic_pkg::NMI_LEVEL_BIT] = nmi_s;
         rd_val[pic_pkg::NMI_EDGE_BIT] = nmi_edge_q;
      end else if (i_addr == pic_pkg::ADDR_IRQ_SENSE) begin
         rd_val[pic_pkg::ENC_MODE_BIT] = enc_mode_q;
         rd_val[11:0] = irq_sense_q;
      end else if (i_addr == pic_pkg::ADDR_PORT_SENSE) begin
         rd_val = port_sense_q;
      end else if (i_addr == pic_pkg::ADDR_PORT_EN) begin
         rd_val = port_en_q;
      end
   end

   // read data register
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 16'h0000;
      end else if (i_rd) begin
         o_rdata <= rd_val;
      end else begin
         o_rdata <= 16'h0000;
      end
   end

   // nmi edge detect per selected polarity
   assign nmi_fire = nmi_edge_q ? (nmi_s && !nmi_prev_q) : (!nmi_s && nmi_prev_q);

   // nmi pending, a new edge wins over the ack
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         nmi_prev_q <= 1'b0;
         nmi_pend_q <= 1'b0;
      end else begin
         nmi_prev_q <= nmi_s;
         if (nmi_fire) begin
            nmi_pend_q <= 1'b1;
         end else if (i_nmi_ack) begin
            nmi_pend_q <= 1'b0;
         end
      end
   end

   // irq detection, edges latched and levels live
   assign int_clear = i_int_ack && o_int_req;
   for (genvar n = 0; n < 6; n++) begin : g_irq
      logic [1:0] sense;
      logic edge_seen;
      assign sense = irq_sense_q[2*n +: 2];
      assign edge_seen = (sense == pic_pkg::SENSE_RISE) ? (irq_s[n] && !irq_prev_q[n]) :
                         (sense == pic_pkg::SENSE_FALL) ? (!irq_s[n] && irq_prev_q[n]) :
                         1'b0;
      always_ff @(posedge i_clk or posedge i_rst) begin
         if (i_rst) begin
            irq_prev_q[n] <= 1'b0;
            irq_pend_q[n] <= 1'b0;
         end else begin
            irq_prev_q[n] <= irq_s[n];
            if (edge_seen) begin
               irq_pend_q[n] <= 1'b1;
            end else if (int_clear && (o_int_src == 5'(pic_pkg::SRC_IRQ0 + n))) begin
               irq_pend_q[n] <= 1'b0;
            end
         end
      end
      assign irq_hit[n] = (sense == pic_pkg::SENSE_LOW) ? !irq_s[n] :
                          (sense == pic_pkg::SENSE_HIGH) ? irq_s[n] : irq_pend_q[n];
   end

   // port sense chooses low or high level
   assign port_hit = ~(port_s ^ port_sense_q) & port_en_q;

   // encoded bus code, active low on shared pins
   assign enc_code = irq_s[3:0];

   // encoded mode hides irq3..0 as single pins
   assign req[pic_pkg::NPERIPH-1:0] = i_periph_req;
   assign req[pic_pkg::SRC_IRQ0 +: 4] = enc_mode_q ? 4'h0 : irq_hit[3:0];
   assign req[pic_pkg::SRC_IRQ0+4 +: 2] = irq_hit[5:4];
   assign req[pic_pkg::SRC_PORT_LO] = |port_hit[7:0];
   assign req[pic_pkg::SRC_PORT_HI] = |port_hit[15:8];
   // reset zeros in the synchroniser would look like code 0, level 15
   assign req[pic_pkg::SRC_ENC] = pins_ok_q[1] && enc_mode_q && (enc_code != pic_pkg::ENC_IDLE);

   // fields taken four bits at a time
   // timers, rtc, watchdog, refresh, irq and port groups
   assign lvl[0*4 +: 4] = fld(prio_q[0], 3);
   assign lvl[1*4 +: 4] = fld(prio_q[0], 2);
   assign lvl[2*4 +: 4] = fld(prio_q[0], 1);
   assign lvl[3*4 +: 4] = fld(prio_q[0], 0);
   assign lvl[4*4 +: 4] = fld(prio_q[1], 3);
   assign lvl[5*4 +: 4] = fld(prio_q[1], 2);
   assign lvl[(pic_pkg::SRC_IRQ0+3)*4 +: 4] = fld(prio_q[2], 3);
   assign lvl[(pic_pkg::SRC_IRQ0+2)*4 +: 4] = fld(prio_q[2], 2);
   assign lvl[(pic_pkg::SRC_IRQ0+1)*4 +: 4] = fld(prio_q[2], 1);
   assign lvl[(pic_pkg::SRC_IRQ0+0)*4 +: 4] = fld(prio_q[2], 0);
   assign lvl[pic_pkg::SRC_PORT_LO*4 +: 4] = fld(prio_q[3], 3);
   assign lvl[pic_pkg::SRC_PORT_HI*4 +: 4] = fld(prio_q[3], 2);
   assign lvl[(pic_pkg::SRC_IRQ0+5)*4 +: 4] = fld(prio_q[3], 1);
   assign lvl[(pic_pkg::SRC_IRQ0+4)*4 +: 4] = fld(prio_q[3], 0);
   // dma, serial, adc, usb and pulse units
   assign lvl[6*4 +: 4] = fld(prio_q[4], 3);
   assign lvl[7*4 +: 4] = fld(prio_q[4], 2);
   assign lvl[8*4 +: 4] = fld(prio_q[4], 1);
   assign lvl[9*4 +: 4] = fld(prio_q[4], 0);
   assign lvl[10*4 +: 4] = fld(prio_q[5], 1);
   assign lvl[11*4 +: 4] = fld(prio_q[6], 3);
   assign lvl[12*4 +: 4] = fld(prio_q[6], 2);
   assign lvl[13*4 +: 4] = fld(prio_q[7], 3);
   assign lvl[14*4 +: 4] = fld(prio_q[7], 2);
   // encoded bus carries its own level, code 0 is level 15
   assign lvl[pic_pkg::SRC_ENC*4 +: 4] = ~enc_code;

   // level 0 never wins against an empty field
   pic_arbiter #(.N(pic_pkg::NSRC)) u_arb (
      .i_req(req),
      .i_lvl(lvl),
      .o_lvl(win_lvl),
      .o_idx(win_idx)
   );

   // present only above the cpu mask level
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_int_req <= 1'b0;
         o_int_level <= 4'h0;
         o_int_src <= 5'h00;
         o_nmi_req <= 1'b0;
      end else begin
         o_int_req <= (win_lvl > i_cpu_mask) && !int_clear;
         o_int_level <= win_lvl;
         o_int_src <= win_idx;
         o_nmi_req <= nmi_pend_q && !i_nmi_ack;
      end
   end

   // assertions
   property p_prio_write;
      @(posedge i_clk) disable iff (i_rst)
      i_wr && (i_addr == pic_pkg::ADDR_PRIO_A) |=> prio_q[0] == $past(i_wdata);
   endproperty
   a_prio_write: assert property (p_prio_write)
      else $error("priority register a did not store write data");

   property p_reserved_zero;
      @(posedge i_clk) disable iff (i_rst)
      i_rd && (i_addr == 4'h1) |=> o_rdata[7:0] == 8'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved priority field read nonzero");

   property p_nmi_level;
      @(posedge i_clk) disable iff (i_rst)
      i_rd && (i_addr == pic_pkg::ADDR_NMI_CTRL) |=> o_rdata[15] == $past(nmi_s);
   endproperty
   a_nmi_level: assert property (p_nmi_level)
      else $error("nmi level bit does not show pin");

   property p_nmi_edge;
      @(posedge i_clk) disable iff (i_rst)
      nmi_edge_q && $rose(nmi_s) |=> nmi_pend_q ##1 o_nmi_req || $past(i_nmi_ack);
   endproperty
   a_nmi_edge: assert property (p_nmi_edge)
      else $error("rising nmi edge not caught");

   property p_nmi_unmasked;
      @(posedge i_clk) disable iff (i_rst)
      nmi_pend_q && !i_nmi_ack |=> o_nmi_req;
   endproperty
   a_nmi_unmasked: assert property (p_nmi_unmasked)
      else $error("nmi request blocked");

   property p_mask_level;
      @(posedge i_clk) disable iff (i_rst)
      o_int_req |-> o_int_level > $past(i_cpu_mask);
   endproperty
   a_mask_level: assert property (p_mask_level)
      else $error("request presented at or below mask");

   property p_level_zero;
      @(posedge i_clk) disable iff (i_rst)
      o_int_req |-> o_int_level != 4'h0;
   endproperty
   a_level_zero: assert property (p_level_zero)
      else $error("level zero source forwarded");

   property p_enc_hides;
      @(posedge i_clk) disable iff (i_rst)
      $past(enc_mode_q) && o_int_req |-> (o_int_src < 5'(pic_pkg::SRC_IRQ0)) ||
         (o_int_src > 5'(pic_pkg::SRC_IRQ0 + 3));
   endproperty
   a_enc_hides: assert property (p_enc_hides)
      else $error("single irq request in encoded mode");

   property p_port_enable;
      @(posedge i_clk) disable iff (i_rst)
      ($past(port_en_q[7:0]) == 8'h00) && o_int_req |-> o_int_src != 5'(pic_pkg::SRC_PORT_LO);
   endproperty
   a_port_enable: assert property (p_port_enable)
      else $error("disabled port group requested");

   c_int_fwd: cover property (@(posedge i_clk) disable iff (i_rst) o_int_req && i_int_ack);
   c_nmi: cover property (@(posedge i_clk) disable iff (i_rst) o_nmi_req);
   c_enc: cover property (@(posedge i_clk) disable iff (i_rst) req[pic_pkg::SRC_ENC]);
endmodule

/* File: pic_cpu_model.sv */
// cpu core model: takes presented requests after a programmable delay
`timescale 1ns/1ps
module pic_cpu_model (
   input wire logic i_clk,          // system clock
   input wire logic i_rst,          // async reset, active high
   input wire logic i_int_req,      // maskable request from controller
   input wire logic i_nmi_req,      // nmi request from controller
   input wire logic i_ack_en,       // cpu willing to take requests
   input wire logic [3:0] i_delay,  // cycles of hesitation before taking
   output logic o_int_ack,          // maskable request taken
   output logic o_nmi_ack           // nmi taken
);
   logic [3:0] int_cnt_q;
   logic [3:0] nmi_cnt_q;

   // take a maskable request only while it is presented
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         int_cnt_q <= 4'h0;
         o_int_ack <= 1'b0;
      end else begin
         o_int_ack <= 1'b0;
         if (o_int_ack || !i_int_req || !i_ack_en) begin
            int_cnt_q <= 4'h0;
         end else if (int_cnt_q >= i_delay) begin
            o_int_ack <= 1'b1;
         end else begin
            int_cnt_q <= int_cnt_q + 4'h1;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         nmi_cnt_q <= 4'h0;
         o_nmi_ack <= 1'b0;
      end else begin
         o_nmi_ack <= 1'b0;
         if (o_nmi_ack || !i_nmi_req || !i_ack_en) begin
            nmi_cnt_q <= 4'h0;
         end else if (nmi_cnt_q >= i_delay) begin
            o_nmi_ack <= 1'b1;
         end else begin
            nmi_cnt_q <= nmi_cnt_q + 4'h1;
         end
      end
   end
endmodule

/* File: pic_pkg.sv */
// constants for the priority interrupt controller
package pic_pkg;
   // register word indices on the plain register port
   localparam logic [3:0] ADDR_PRIO_A = 4'h0;
   localparam logic [3:0] ADDR_PRIO_H = 4'h7;
   localparam logic [3:0] ADDR_NMI_CTRL = 4'h8;
   localparam logic [3:0] ADDR_IRQ_SENSE = 4'h9;
   localparam logic [3:0] ADDR_PORT_SENSE = 4'hA;
   localparam logic [3:0] ADDR_PORT_EN = 4'hB;
   // writable-bit masks of the eight priority registers, a first
   localparam logic [15:0] PRIO_WMASK [8] = '{16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFFFF,
                                             16'hFFFF, 16'h00F0, 16'hFF00, 16'hFF00};
   localparam logic [15:0] PRIO_RESET = 16'h0000;
   // nonmask_pin_control fields
   localparam int NMI_LEVEL_BIT = 15;
   localparam int NMI_EDGE_BIT = 8;
   localparam logic NMI_EDGE_RESET = 1'b0;
   // irq_sense_control fields
   localparam int ENC_MODE_BIT = 14;
   localparam logic ENC_MODE_RESET = 1'b1;
   localparam logic [11:0] IRQ_SENSE_RESET = 12'h000;
   localparam logic [15:0] PORT_RESET = 16'h0000;
   // sense codes per irq pin
   localparam logic [1:0] SENSE_FALL = 2'h0;
   localparam logic [1:0] SENSE_RISE = 2'h1;
   localparam logic [1:0] SENSE_LOW = 2'h2;
   localparam logic [1:0] SENSE_HIGH = 2'h3;
   // source numbering: 0..14 peripherals, then irq, port groups, encoded bus
   localparam int NPERIPH = 15;
   localparam int NSRC = 24;
   localparam int SRC_IRQ0 = 15;
   localparam int SRC_PORT_LO = 21;
   localparam int SRC_PORT_HI = 22;
   localparam int SRC_ENC = 23;
   localparam logic [3:0] ENC_IDLE = 4'hF;
endpackage

/* File: pic_sync.sv */
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pic_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,          // system clock
   input wire logic i_rst,          // async reset, active high
   input wire logic [W-1:0] i_d,    // raw pin levels
   output logic [W-1:0] o_q         // synchronised levels
);
   logic [W-1:0] meta_q;

   // first stage feeds only the second
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_q <= '0;
         o_q <= '0;
      end else begin
         meta_q <= i_d;
         o_q <= meta_q;
      end
   end
endmodule

/* File: tb_top.sv */
// self-checking bench for the priority interrupt controller
`timescale 1ns/1ps
module tb_top;
   logic i_clk, i_rst, i_wr, i_rd, i_nmi, i_int_ack, i_nmi_ack, o_int_req, o_nmi_req;
   logic [3:0] i_addr, i_cpu_mask, o_int_level, ack_delay;
   logic [15:0] i_wdata, o_rdata, i_port_pins;
   logic [5:0] i_irq;
   logic [14:0] i_periph_req;
   logic [4:0] o_int_src;
   logic ack_en;
   int err_count, check_count;
   // register and field shift of each peripheral source
   localparam int FREG [15] = '{0, 0, 0, 0, 1, 1, 4, 4, 4, 4, 5, 6, 6, 7, 7};
   localparam int FSH [15] = '{12, 8, 4, 0, 12, 8, 12, 8, 4, 0, 4, 12, 8, 12, 8};
   localparam logic [1:0] SORD [4] = '{pic_pkg::SENSE_FALL, pic_pkg::SENSE_LOW,
                                       pic_pkg::SENSE_RISE, pic_pkg::SENSE_HIGH};

   pic_controller pic_controller_inst (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_nmi(i_nmi),
      .i_irq(i_irq), .i_port_pins(i_port_pins), .i_periph_req(i_periph_req),
      .i_cpu_mask(i_cpu_mask), .i_int_ack(i_int_ack), .i_nmi_ack(i_nmi_ack),
      .o_int_req(o_int_req), .o_int_level(o_int_level), .o_int_src(o_int_src),
      .o_nmi_req(o_nmi_req));
   pic_cpu_model pic_cpu_model_inst (.i_clk(i_clk), .i_rst(i_rst), .i_int_req(o_int_req),
      .i_nmi_req(o_nmi_req), .i_ack_en(ack_en), .i_delay(ack_delay),
      .o_int_ack(i_int_ack), .o_nmi_ack(i_nmi_ack));

   // 125 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   task automatic results;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(negedge i_clk);
      chk(o_rdata, exp);
   endtask

   // cpu-side outputs; level and source only matter while requesting
   task automatic intchk(input int n, input logic nm, input logic r, input logic [3:0] l,
                         input logic [4:0] s);
      repeat (n) @(posedge i_clk);
      @(negedge i_clk);
      if (r) begin
         chk({5'h00, o_nmi_req, o_int_req, o_int_level, o_int_src}, {5'h00, nm, r, l, s});
      end else begin
         chk({14'h0000, o_nmi_req, o_int_req}, {14'h0000, nm, 1'b0});
      end
      @(posedge i_clk);
   endtask

   // watchdog
   initial begin
      repeat (20000) @(posedge i_clk);
      err_count++;
      results();
   end

   // main sequence
   initial begin
      i_rst = 1'b1;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 4'h0;
      i_wdata = 16'h0000;
      i_nmi = 1'b1;
      i_irq = 6'h3F;
      i_port_pins = 16'h0000;
      i_periph_req = 15'h0000;
      i_cpu_mask = 4'h0;
      ack_en = 1'b0;
      ack_delay = 4'h0;
      err_count = 0;
      check_count = 0;
      repeat (12) @(posedge i_clk);
      i_rst <= 1'b0;
      // no request while the pin synchronisers still hold reset zeros
      intchk(1, 1'b0, 1'b0, 4'h0, 5'h00);
      for (int i = 0; i < 8; i++) rdchk(4'(i), pic_pkg::PRIO_RESET);
      rdchk(pic_pkg::ADDR_NMI_CTRL, 16'h8000);
      rdchk(pic_pkg::ADDR_IRQ_SENSE, 16'h4000);
      rdchk(pic_pkg::ADDR_PORT_SENSE, 16'h0000);
      rdchk(pic_pkg::ADDR_PORT_EN, 16'h0000);
      // all ones written, reserved fields must stay zero
      for (int i = 0; i < 8; i++) begin
         wr(4'(i), 16'hFFFF);
         rdchk(4'(i), pic_pkg::PRIO_WMASK[i]);
         wr(4'(i), 16'h0000);
      end
      wr(4'hC, 16'hFFFF);
      rdchk(4'hC, 16'h0000);
      wr(pic_pkg::ADDR_NMI_CTRL, 16'hFFFF);
      rdchk(pic_pkg::ADDR_NMI_CTRL, 16'h8100);
      wr(pic_pkg::ADDR_NMI_CTRL, 16'h0000);
      // each peripheral through its own field, mask boundary, level zero
      for (int k = 0; k < 15; k++) begin
         wr(4'(FREG[k]), 16'h0005 << FSH[k]);
         i_periph_req[k] <= 1'b1;
         intchk(3, 1'b0, 1'b1, 4'h5, 5'(k));
         i_cpu_mask <= 4'h5;
         intchk(3, 1'b0, 1'b0, 4'h0, 5'h00);
         i_cpu_mask <= 4'h0;
         wr(4'(FREG[k]), 16'h0000);
         intchk(3, 1'b0, 1'b0, 4'h0, 5'h00);
         i_periph_req[k] <= 1'b0;
      end
      // highest level wins, lower index on a tie
      wr(pic_pkg::ADDR_PRIO_A, 16'h3000);
      wr(4'h4, 16'h000C);
      i_periph_req <= 15'h0201;
      i_cpu_mask <= 4'hB;
      intchk(3, 1'b0, 1'b1, 4'hC, 5'd9);
      wr(pic_pkg::ADDR_PRIO_A, 16'hC000);
      intchk(3, 1'b0, 1'b1, 4'hC, 5'd0);
      i_periph_req <= 15'h0000;
      i_cpu_mask <= 4'h0;
      wr(4'h4, 16'h0000);
      wr(pic_pkg::ADDR_PRIO_A, 16'h0000);
      // irq0 in every sense mode; edges latch until the cpu takes them
      wr(4'h2, 16'h0007);
      for (int m = 0; m < 4; m++) begin
         wr(pic_pkg::ADDR_IRQ_SENSE, {14'h0000, SORD[m]});
         i_irq[0] <= ~SORD[m][0];
         intchk(6, 1'b0, 1'b0, 4'h0, 5'h00);
         i_irq[0] <= SORD[m][0];
         intchk(6, 1'b0, 1'b1, 4'h7, 5'd15);
         i_irq[0] <= ~SORD[m][0];
         intchk(6, 1'b0, !SORD[m][1], 4'h7, 5'd15);
         ack_en <= 1'b1;
         intchk(8, 1'b0, 1'b0, 4'h0, 5'h00);
         ack_en <= 1'b0;
      end
      // encoded bus owns irq3..0; irq5 keeps its own field
      wr(pic_pkg::ADDR_IRQ_SENSE, 16'h4C03);
      i_irq[3:0] <= 4'h3;
      intchk(6, 1'b0, 1'b1, 4'hC, 5'd23);
      i_cpu_mask <= 4'hC;
      intchk(3, 1'b0, 1'b0, 4'h0, 5'h00);
      i_cpu_mask <= 4'h0;
      i_irq[3:0] <= pic_pkg::ENC_IDLE;
      wr(4'h2, 16'h0000);
      wr(4'h3, 16'h0090);
      intchk(6, 1'b0, 1'b1, 4'h9, 5'd20);
      // port pin group: sense and enable
      wr(4'h3, 16'hA000);
      i_port_pins <= 16'h0004;
      wr(pic_pkg::ADDR_PORT_SENSE, 16'h0004);
      intchk(6, 1'b0, 1'b0, 4'h0, 5'h00);
      wr(pic_pkg::ADDR_PORT_EN, 16'h0004);
      intchk(6, 1'b0, 1'b1, 4'hA, 5'd21);
      wr(pic_pkg::ADDR_PORT_SENSE, 16'h0000);
      intchk(6, 1'b0, 1'b0, 4'h0, 5'h00);
      i_port_pins <= 16'h0000;
      intchk(6, 1'b0, 1'b1, 4'hA, 5'd21);
      wr(4'h3, 16'h0000);
      // nmi ignores the mask; level bit checked in service
      ack_delay <= 4'h3;
      i_cpu_mask <= 4'hF;
      i_nmi <= 1'b0;
      intchk(6, 1'b1, 1'b0, 4'h0, 5'h00);
      rdchk(pic_pkg::ADDR_NMI_CTRL, 16'h0000);
      @(posedge i_clk);
      ack_en <= 1'b1;
      intchk(8, 1'b0, 1'b0, 4'h0, 5'h00);
      ack_en <= 1'b0;
      wr(pic_pkg::ADDR_NMI_CTRL, 16'h0100);
      i_nmi <= 1'b1;
      intchk(6, 1'b1, 1'b0, 4'h0, 5'h00);
      rdchk(pic_pkg::ADDR_NMI_CTRL, 16'h8100);
      @(posedge i_clk);
      ack_en <= 1'b1;
      intchk(8, 1'b0, 1'b0, 4'h0, 5'h00);
      i_nmi <= 1'b0;
      intchk(8, 1'b0, 1'b0, 4'h0, 5'h00);
      results();
   end
endmodule
